/* File: design/touch_pkg.sv */
/*
  Constants, types and helpers shared by the touch screen conversion sequencer.
  Assumes a 250 MHz clock; every slower rate comes from one 500 ns tick enable.
*/
package touch_pkg;
// Notes on behaviour
// - Thermal mask bit 15 set stops temperature results from raising an interrupt.
// - Mask bit 14 set stops auxiliary or battery results from raising an interrupt.
// - Bit 13 picks data-available (0) or limit alert (1); flags are set only in alert mode.
// - Bit 12 clear lets the general-purpose pin alert; set masks it.
// - Flags: bit 11 extra low, 10 extra high, 9 thermal low, 8 thermal high.
// - Include bits 7 to 1: Y, X, pressure a, pressure b, aux, battery, thermal.
// - In sequences, GPIO enabled skips aux and battery; both selected skips aux only.
// - Results land in read-only registers 0x08 to 0x0D; aux and battery share 0x0C.
// - Register 0x0E reads identity in [7:0], revision in [11:8], zero above.
// - Interval zero, the reset value, means one conversion or sequence only, or one per touch in master.
// - Slave operation starts the interval timer as soon as a sequence ends.
// - Master timer runs only while touched; release stops it, touch restarts.
// - Sample window code 00..11 gives 4, 8, 16 or 32 converter periods.
// - Mode 00 idle, 01 single slave, 10 slave sequence, 11 master sequence.
// - Single mode converts only the channel in main control [14:12].
// - Single or slave sequence with zero interval clears the mode to 00 at end.
// - Single or slave sequence with nonzero interval repeats at that interval.
// - Writing mode 10 converts every included channel left after those skips and stores each result.
// - Mode 11 waits for a touch before converting the selected sequence.
// - Master starts again only on a new touch or a timer event while held.
// - Main control bit 15 zero: pin shows touch, low; one: pin shows data-available or alerts per bit 13.
// - Settling delay before first conversion and before position and pressure.

  localparam logic [3:0] ADDR_CONV_CTRL = 4'h1;
  localparam logic [3:0] ADDR_IRQ_SEQ   = 4'h3;
  localparam logic [3:0] ADDR_LIM_BASE  = 4'h4;
  localparam logic [3:0] ADDR_RES_BASE  = 4'h8;
  localparam logic [3:0] ADDR_RES_LAST  = 4'hD;
  localparam logic [3:0] ADDR_ID        = 4'hE;
  localparam logic [15:0] RESET_WORD    = 16'h0000;

  localparam int CC_PIN_FUNC = 15;
  localparam int CC_CHAN_LO  = 12;
  localparam int CC_MODE_LO  = 10;
  localparam int CC_ACQ_LO   = 8;
  localparam int CC_TMR_LO   = 0;

  localparam int IS_TH_MASK  = 15;
  localparam int IS_XB_MASK  = 14;
  localparam int IS_INT_MODE = 13;
  localparam int IS_GP_MASK  = 12;
  localparam int IS_FLAG_LO  = 8;
  localparam int IS_INC_LO   = 1;

  localparam int FL_TH_HIGH = 0;
  localparam int FL_TH_LOW  = 1;
  localparam int FL_XB_HIGH = 2;
  localparam int FL_XB_LOW  = 3;
  localparam int LIM_XB_HI  = 0;
  localparam int LIM_XB_LO  = 1;
  localparam int LIM_TH_HI  = 2;
  localparam int LIM_TH_LO  = 3;
  localparam int INC_AUX    = 2;
  localparam int INC_BAT    = 1;

  localparam logic [2:0] CH_NONE      = 3'h0;
  localparam logic [2:0] CH_THERM     = 3'h1;
  localparam logic [2:0] CH_BAT       = 3'h2;
  localparam logic [2:0] CH_AUX       = 3'h3;
  localparam logic [2:0] CH_SETTLE_LO = 3'h4;

  // Arbitrary identity values
  localparam logic [7:0] ID_CODE_DEFAULT  = 8'h5A;
  localparam logic [3:0] REV_CODE_DEFAULT = 4'h3;

  localparam int CLK_MHZ           = 250;
  localparam int TICK_NS           = 500;
  localparam int TICK_CYCLES       = TICK_NS * CLK_MHZ / 1000;
  localparam int TICKS_PER_US      = 1000 / TICK_NS;
  localparam int INTERVAL_FIRST_US = 550;
  localparam int INTERVAL_STEP_US  = 35;
  localparam int ACQ_BASE_PERIODS  = 4;

  typedef enum logic [1:0] {MODE_OFF, MODE_SINGLE, MODE_SLAVE_SEQ, MODE_MASTER_SEQ} mode_t;
  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_TOUCH, S_WAIT_RELEASE, S_NEXT, S_SETTLE, S_ACQ, S_CONV, S_INTERVAL
  } seq_state_t;

  function automatic logic [12:0] settle_us(input logic [3:0] sel);
    case (sel)
      4'h0:    settle_us = 13'h0080;
      4'h1:    settle_us = 13'h0100;
      4'h2:    settle_us = 13'h0180;
      4'h3:    settle_us = 13'h0200;
      4'h4:    settle_us = 13'h0280;
      4'h5:    settle_us = 13'h0300;
      4'h6:    settle_us = 13'h0380;
      4'h7:    settle_us = 13'h0400;
      4'h8:    settle_us = 13'h0480;
      4'h9:    settle_us = 13'h0500;
      4'hA:    settle_us = 13'h0600;
      4'hB:    settle_us = 13'h0700;
      4'hC:    settle_us = 13'h0800;
      4'hD:    settle_us = 13'h0A00;
      4'hE:    settle_us = 13'h0E00;
      default: settle_us = 13'h1000;
    endcase
  endfunction
endpackage

/* File: design/tick_gen.sv */
/*
  Divider giving a one-cycle enable every CYCLES clocks.
  Assumes restart is pulsed whenever a new interval is loaded.
*/
`timescale 1ns/10ps
module tick_gen #(
  parameter int unsigned CYCLES = 125
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);
  logic [15:0] cnt_q;

  if (CYCLES < 2 || CYCLES > 65535) begin : g_bad_cycles
    $error("tick_gen: CYCLES out of range");
  end

  // Restart keeps the first tick a full period after a load
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (restart) begin
      // Start at one, as the tick itself costs a clock
      cnt_q <= 16'h0001;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(CYCLES - 1)) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule

/* File: design/touch_seq.sv */
/*
  Conversion sequencer, register file, limit check and interrupt pin logic.
  Assumes a serial front end giving one-cycle register strobes and a converter
  that answers each conv_start with one conv_done pulse.
*/
`timescale 1ns/10ps
module touch_seq #(
  parameter int unsigned TICK_CYCLES = touch_pkg::TICK_CYCLES,
  parameter logic [7:0]  ID_CODE     = touch_pkg::ID_CODE_DEFAULT,
  parameter logic [3:0]  REV_CODE    = touch_pkg::REV_CODE_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_rd_valid,
  input  wire logic        touch_detected,
  input  wire logic        gpio_enable,
  input  wire logic        gpio_alert_in,
  input  wire logic [3:0]  settle_delay_select,
  output logic             sample_active,
  output logic [2:0]       conv_chan,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  output logic             irq_pin_n
);
  logic [15:0]            ctrl1_q;
  logic [15:0]            ctrl3_q;
  logic [15:0]            lim_q [4];
  logic [15:0]            res_q [6];
  touch_pkg::seq_state_t  state_q;
  touch_pkg::seq_state_t  state_d;
  touch_pkg::mode_t       mode;
  logic [6:0]             remain_q;
  logic [6:0]             incl;
  logic [6:0]             plan;
  logic                   first_q;
  logic                   dav_q;
  logic [14:0]            timer_q;
  logic [14:0]            load_val;
  logic                   load_en;
  logic                   tick;
  logic                   t_exp;
  logic                   start_seq;
  logic                   take_chan;
  logic                   seq_end;
  logic                   clear_mode;
  logic [2:0]             next_ch;
  logic [2:0]             single_ch;
  logic [7:0]             tmr;
  logic                   wr_c1;
  logic                   wr_c3;
  logic                   capture;
  logic                   res_read;
  logic                   alert;
  logic [3:0]             fl_set;
  logic [3:0]             fl_keep;
  logic [14:0]            acq_ticks;
  logic [14:0]            settle_ticks;
  logic [14:0]            interval_ticks;

  function automatic logic [2:0] pick(input logic [6:0] m);
    pick = touch_pkg::CH_NONE;
    for (int k = 0; k < 7; k++) begin
      if (m[k]) begin
        pick = 3'(k + 1);
      end
    end
  endfunction

  function automatic logic [2:0] res_index(input logic [2:0] ch);
    if (ch >= touch_pkg::CH_SETTLE_LO) begin
      res_index = 3'h7 - ch;
    end else if (ch >= touch_pkg::CH_BAT) begin
      res_index = 3'h4;
    end else begin
      res_index = 3'h5;
    end
  endfunction

  tick_gen #(
    .CYCLES  (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .rst     (rst),
    .restart (load_en),
    .tick    (tick)
  );

  assign wr_c1     = reg_wr_en && reg_addr == touch_pkg::ADDR_CONV_CTRL;
  assign wr_c3     = reg_wr_en && reg_addr == touch_pkg::ADDR_IRQ_SEQ;
  assign mode      = touch_pkg::mode_t'(ctrl1_q[touch_pkg::CC_MODE_LO +: 2]);
  assign tmr       = ctrl1_q[touch_pkg::CC_TMR_LO +: 8];
  assign single_ch = ctrl1_q[touch_pkg::CC_CHAN_LO +: 3];
  assign t_exp     = tick && timer_q == 15'h0001;
  assign capture   = state_q == touch_pkg::S_CONV && conv_done;
  assign res_read  = reg_rd_en && reg_addr >= touch_pkg::ADDR_RES_BASE
                     && reg_addr <= touch_pkg::ADDR_RES_LAST;

  // Interval and window lengths in 500 ns ticks
  assign acq_ticks = 15'(touch_pkg::ACQ_BASE_PERIODS) << ctrl1_q[touch_pkg::CC_ACQ_LO +: 2];
  assign settle_ticks = 15'(touch_pkg::settle_us(settle_delay_select) * touch_pkg::TICKS_PER_US);
  assign interval_ticks = 15'(touch_pkg::TICKS_PER_US * (touch_pkg::INTERVAL_FIRST_US
                          + touch_pkg::INTERVAL_STEP_US * (int'(tmr) - 1)));

  always_comb begin
    incl = ctrl3_q[touch_pkg::IS_INC_LO +: 7];
    if (gpio_enable) begin
      incl[touch_pkg::INC_AUX] = 1'b0;
      incl[touch_pkg::INC_BAT] = 1'b0;
    end else if (incl[touch_pkg::INC_AUX] && incl[touch_pkg::INC_BAT]) begin
      incl[touch_pkg::INC_AUX] = 1'b0;
    end
    if (mode == touch_pkg::MODE_SINGLE) begin
      // Channel code zero is invalid and gives an empty sequence
      plan = (single_ch == touch_pkg::CH_NONE) ? 7'h00
             : 7'(7'h01 << (single_ch - 3'h1));
    end else begin
      plan = incl;
    end
  end

  always_comb begin
    state_d    = state_q;
    load_en    = 1'b0;
    load_val   = acq_ticks;
    start_seq  = 1'b0;
    take_chan  = 1'b0;
    seq_end    = 1'b0;
    clear_mode = 1'b0;
    next_ch    = pick(remain_q);
    case (state_q)
      touch_pkg::S_IDLE: begin
        if (mode == touch_pkg::MODE_MASTER_SEQ) begin
          state_d = touch_pkg::S_WAIT_TOUCH;
        end else if (mode != touch_pkg::MODE_OFF) begin
          start_seq = 1'b1;
        end
      end
      touch_pkg::S_WAIT_TOUCH: begin
        if (touch_detected) begin
          start_seq = 1'b1;
        end
      end
      touch_pkg::S_WAIT_RELEASE: begin
        if (!touch_detected) begin
          state_d = touch_pkg::S_WAIT_TOUCH;
        end
      end
      touch_pkg::S_NEXT: begin
        if (next_ch == touch_pkg::CH_NONE) begin
          seq_end = 1'b1;
          if (mode == touch_pkg::MODE_MASTER_SEQ) begin
            if (touch_detected && tmr != 8'h00) begin
              state_d  = touch_pkg::S_INTERVAL;
              load_en  = 1'b1;
              load_val = interval_ticks;
            end else if (touch_detected) begin
              state_d = touch_pkg::S_WAIT_RELEASE;
            end else begin
              state_d = touch_pkg::S_WAIT_TOUCH;
            end
          end else if (tmr != 8'h00) begin
            state_d  = touch_pkg::S_INTERVAL;
            load_en  = 1'b1;
            load_val = interval_ticks;
          end else begin
            state_d    = touch_pkg::S_IDLE;
            clear_mode = 1'b1;
          end
        end else begin
          take_chan = 1'b1;
          load_en   = 1'b1;
          if (first_q || next_ch >= touch_pkg::CH_SETTLE_LO) begin
            state_d  = touch_pkg::S_SETTLE;
            load_val = settle_ticks;
          end else begin
            state_d = touch_pkg::S_ACQ;
          end
        end
      end
      touch_pkg::S_SETTLE: begin
        if (t_exp) begin
          state_d = touch_pkg::S_ACQ;
          load_en = 1'b1;
        end
      end
      touch_pkg::S_ACQ: begin
        if (t_exp) begin
          state_d = touch_pkg::S_CONV;
        end
      end
      touch_pkg::S_CONV: begin
        if (conv_done) begin
          state_d = touch_pkg::S_NEXT;
        end
      end
      touch_pkg::S_INTERVAL: begin
        if (mode == touch_pkg::MODE_MASTER_SEQ && !touch_detected) begin
          state_d = touch_pkg::S_WAIT_TOUCH;
        end else if (t_exp) begin
          start_seq = 1'b1;
        end
      end
      default: begin
        state_d = touch_pkg::S_IDLE;
      end
    endcase
    if (start_seq) begin
      state_d = touch_pkg::S_NEXT;
    end
    // Any write of the main control register restarts from idle
    if (wr_c1) begin
      state_d    = touch_pkg::S_IDLE;
      load_en    = 1'b0;
      start_seq  = 1'b0;
      take_chan  = 1'b0;
      clear_mode = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= touch_pkg::S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_q <= 15'h0000;
    end else if (load_en) begin
      timer_q <= load_val;
    end else if (tick && timer_q != 15'h0000) begin
      timer_q <= timer_q - 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      remain_q  <= 7'h00;
      first_q   <= 1'b0;
      conv_chan <= touch_pkg::CH_NONE;
    end else if (start_seq) begin
      remain_q <= plan;
      first_q  <= 1'b1;
    end else if (take_chan) begin
      remain_q[3'(next_ch - 3'h1)] <= 1'b0;
      first_q                      <= 1'b0;
      conv_chan                    <= next_ch;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sample_active <= 1'b0;
      conv_start    <= 1'b0;
    end else begin
      sample_active <= state_d == touch_pkg::S_ACQ;
      conv_start    <= state_q == touch_pkg::S_ACQ && t_exp && !wr_c1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1_q <= touch_pkg::RESET_WORD;
    end else if (wr_c1) begin
      ctrl1_q <= reg_wdata;
    end else if (clear_mode) begin
      ctrl1_q[touch_pkg::CC_MODE_LO +: 2] <= touch_pkg::MODE_OFF;
    end
  end

  // Limit check; masked channels never set flags
  always_comb begin
    fl_set = 4'h0;
    if (capture && ctrl3_q[touch_pkg::IS_INT_MODE]) begin
      if (conv_chan == touch_pkg::CH_THERM && !ctrl3_q[touch_pkg::IS_TH_MASK]) begin
        fl_set[touch_pkg::FL_TH_HIGH] = conv_data > lim_q[touch_pkg::LIM_TH_HI];
        fl_set[touch_pkg::FL_TH_LOW]  = conv_data < lim_q[touch_pkg::LIM_TH_LO];
      end
      if ((conv_chan == touch_pkg::CH_AUX || conv_chan == touch_pkg::CH_BAT)
          && !ctrl3_q[touch_pkg::IS_XB_MASK]) begin
        fl_set[touch_pkg::FL_XB_HIGH] = conv_data > lim_q[touch_pkg::LIM_XB_HI];
        fl_set[touch_pkg::FL_XB_LOW]  = conv_data < lim_q[touch_pkg::LIM_XB_LO];
      end
    end
    fl_keep = ctrl3_q[touch_pkg::IS_FLAG_LO +: 4];
    if (wr_c3) begin
      fl_keep = fl_keep & reg_wdata[touch_pkg::IS_FLAG_LO +: 4];
    end
  end

  // A new violation wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl3_q <= touch_pkg::RESET_WORD;
    end else begin
      if (wr_c3) begin
        ctrl3_q[15:12] <= reg_wdata[15:12];
        ctrl3_q[7:0]   <= {reg_wdata[7:1], 1'b0};
      end
      ctrl3_q[touch_pkg::IS_FLAG_LO +: 4] <= fl_keep | fl_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        lim_q[i] <= touch_pkg::RESET_WORD;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (reg_wr_en && reg_addr == touch_pkg::ADDR_LIM_BASE + 4'(i)) begin
          lim_q[i] <= reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) begin
        res_q[i] <= touch_pkg::RESET_WORD;
      end
    end else if (capture) begin
      res_q[res_index(conv_chan)] <= conv_data;
    end
  end

  // Fresh-data marker; completion wins over a result read
  always_ff @(posedge clk) begin
    if (rst) begin
      dav_q <= 1'b0;
    end else if (seq_end) begin
      dav_q <= 1'b1;
    end else if (start_seq || res_read) begin
      dav_q <= 1'b0;
    end
  end

  assign alert = |ctrl3_q[touch_pkg::IS_FLAG_LO +: 4]
                 || (gpio_enable && !ctrl3_q[touch_pkg::IS_GP_MASK] && gpio_alert_in);

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_pin_n <= 1'b1;
    end else if (!ctrl1_q[touch_pkg::CC_PIN_FUNC]) begin
      irq_pin_n <= !touch_detected;
    end else if (ctrl3_q[touch_pkg::IS_INT_MODE]) begin
      irq_pin_n <= !alert;
    end else begin
      irq_pin_n <= !dav_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata    <= touch_pkg::RESET_WORD;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        if (reg_addr == touch_pkg::ADDR_CONV_CTRL) begin
          reg_rdata <= ctrl1_q;
        end else if (reg_addr == touch_pkg::ADDR_IRQ_SEQ) begin
          reg_rdata <= ctrl3_q;
        end else if (reg_addr >= touch_pkg::ADDR_LIM_BASE && reg_addr < touch_pkg::ADDR_RES_BASE) begin
          reg_rdata <= lim_q[2'(reg_addr - touch_pkg::ADDR_LIM_BASE)];
        end else if (res_read) begin
          reg_rdata <= res_q[3'(reg_addr - touch_pkg::ADDR_RES_BASE)];
        end else if (reg_addr == touch_pkg::ADDR_ID) begin
          reg_rdata <= {4'h0, REV_CODE, ID_CODE};
        end else begin
          reg_rdata <= touch_pkg::RESET_WORD;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_mode_clear;
    seq_end && mode != touch_pkg::MODE_MASTER_SEQ && tmr == 8'h00 && !wr_c1
      |=> ctrl1_q[touch_pkg::CC_MODE_LO +: 2] == 2'b00 && state_q == touch_pkg::S_IDLE;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode not cleared");

  property p_slave_timer;
    seq_end && mode != touch_pkg::MODE_MASTER_SEQ && tmr != 8'h00 && !wr_c1
      |=> state_q == touch_pkg::S_INTERVAL && timer_q == $past(interval_ticks);
  endproperty
  a_slave_timer: assert property (p_slave_timer) else $error("timer not started");

  property p_skip_extra;
    conv_start && mode != touch_pkg::MODE_SINGLE
      |-> !(conv_chan == touch_pkg::CH_AUX && (gpio_enable || ctrl3_q[touch_pkg::INC_BAT + 1]))
          && !(conv_chan == touch_pkg::CH_BAT && gpio_enable);
  endproperty
  a_skip_extra: assert property (p_skip_extra) else $error("extra channel not skipped");

  property p_single_chan;
    conv_start && mode == touch_pkg::MODE_SINGLE |-> conv_chan == single_ch;
  endproperty
  a_single_chan: assert property (p_single_chan) else $error("wrong single channel");

  property p_therm_store;
    capture && conv_chan == touch_pkg::CH_THERM |=> res_q[5] == $past(conv_data);
  endproperty
  a_therm_store: assert property (p_therm_store) else $error("thermal result lost");

  property p_id_read;
    reg_rd_en && reg_addr == touch_pkg::ADDR_ID
      |=> reg_rd_valid && reg_rdata == {4'h0, REV_CODE, ID_CODE};
  endproperty
  a_id_read: assert property (p_id_read) else $error("identity read wrong");

  property p_therm_mask;
    capture && conv_chan == touch_pkg::CH_THERM && ctrl3_q[touch_pkg::IS_TH_MASK] && !wr_c3
      |=> $stable(ctrl3_q[9:8]);
  endproperty
  a_therm_mask: assert property (p_therm_mask) else $error("masked thermal flagged");

  property p_touch_pin;
    !ctrl1_q[touch_pkg::CC_PIN_FUNC] && !wr_c1 |=> irq_pin_n == !$past(touch_detected);
  endproperty
  a_touch_pin: assert property (p_touch_pin) else $error("touch pin wrong");

  property p_dav_pin;
    seq_end && ctrl1_q[touch_pkg::CC_PIN_FUNC] && !ctrl3_q[touch_pkg::IS_INT_MODE]
      && !wr_c1 && !wr_c3 |-> ##2 !irq_pin_n;
  endproperty
  a_dav_pin: assert property (p_dav_pin) else $error("data pin not asserted");

  property p_wait_touch;
    state_q == touch_pkg::S_WAIT_TOUCH && !touch_detected && !wr_c1
      |=> state_q == touch_pkg::S_WAIT_TOUCH && !conv_start;
  endproperty
  a_wait_touch: assert property (p_wait_touch) else $error("converted without touch");

  property p_master_release;
    state_q == touch_pkg::S_INTERVAL && mode == touch_pkg::MODE_MASTER_SEQ
      && !touch_detected && !wr_c1 |=> state_q == touch_pkg::S_WAIT_TOUCH;
  endproperty
  a_master_release: assert property (p_master_release) else $error("timer ran after release");

  c_single: cover property (conv_start && mode == touch_pkg::MODE_SINGLE);
  c_repeat: cover property (state_q == touch_pkg::S_INTERVAL ##1 state_q == touch_pkg::S_NEXT);
  c_alert:  cover property (fl_set != 4'h0);
endmodule

/* File: verification/conv_model.sv */
/*
  Converter model: answers each conversion start after three clocks.
  Assumes one start pulse at a time; data is garbled outside the answer.
*/
`timescale 1ns/10ps
module conv_model (
  input  wire logic       clk,
  input  wire logic       conv_start,
  input  wire logic [2:0] conv_chan,
  output logic            conv_done,
  output logic [15:0]     conv_data,
  output int              conv_count,
  output int              extra_hits
);
  initial begin
    conv_done = 1'b0;
    conv_data = 16'hFFFF;
    conv_count = 0;
    extra_hits = 0;
  end
  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      repeat (3) @(posedge clk);
      conv_done <= 1'b1;
      conv_data <= 16'h0100 + {13'h0000, conv_chan};
      conv_count <= conv_count + 1;
      if (conv_chan === 3'h3)
        extra_hits <= extra_hits + 1;
      @(posedge clk);
      conv_done <= 1'b0;
      // Stale data would hide a late sample
      conv_data <= ~conv_data;
    end
  end
endmodule

/* File: verification/touch_seq_tb.sv */
/*
  Bench for the conversion sequencer: register tasks and compares.
  Assumes the converter model answers every start; touch and GPIO driven here.
*/
`timescale 1ns/10ps
module touch_seq_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        rd_valid;
  logic        sample_active;
  logic [2:0]  conv_chan;
  logic        conv_start;
  logic        conv_done;
  logic [15:0] conv_data;
  logic        irq_pin_n;
  logic [15:0] v;
  int          conv_count;
  int          extra_hits;
  logic        touch = 1'b0;
  logic        gpio_en = 1'b0;
  logic        gpio_al = 1'b0;
  int          act_cycles = 0;
  int          mismatches = 0;
  int          num_checks = 0;
  always #2 clk = ~clk;
  // Acquisition window clocks summed over the run
  always @(posedge clk)
    if (sample_active === 1'b1)
      act_cycles++;
  touch_seq #(.TICK_CYCLES(2)) u_touch_seq (.clk(clk), .rst(rst), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rd_valid(rd_valid), .touch_detected(touch), .gpio_enable(gpio_en),
    .gpio_alert_in(gpio_al), .settle_delay_select(4'h0), .sample_active(sample_active),
    .conv_chan(conv_chan), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .irq_pin_n(irq_pin_n));
  conv_model u_conv_model (.clk(clk), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_done(conv_done), .conv_data(conv_data), .conv_count(conv_count),
    .extra_hits(extra_hits));
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic e);
    repeat (2) @(negedge clk);
    cmp({15'h0000, irq_pin_n}, {15'h0000, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge clk);
    {rd_en, addr} = {1'b1, a};
    @(negedge clk);
    rd_en = 1'b0;
    d = rdata;
    cmp({15'h0000, rd_valid}, 16'h0001);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    rd(a, v);
    cmp(v, e);
  endtask
  // Poll the mode field; the sequencer has no done flag of its own
  task automatic wait_idle;
    for (int i = 0; i < 3000; i++) begin
      rd(4'h1, v);
      if (v[11:10] === 2'b00)
        break;
    end
    cmp({14'h0000, v[11:10]}, 16'h0000);
    repeat (2) @(negedge clk);
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rdc(4'h1, 16'h0000);
    rdc(4'h3, 16'h0000);
    rdc(4'hD, 16'h0000);
    rdc(4'hE, {4'h0, touch_pkg::REV_CODE_DEFAULT, touch_pkg::ID_CODE_DEFAULT});
    rdc(4'h0, 16'h0000);
    wr(4'hD, 16'h1234);
    rdc(4'hD, 16'h0000);
    for (int a = 4; a < 8; a++) begin
      wr(4'(a), 16'h0100 + 16'(a));
      rdc(4'(a), 16'h0100 + 16'(a));
    end
    // Alert mode, extra masked: thermal 0x0101 under its low limit
    wr(4'h3, 16'h6006);
    wr(4'h1, 16'h8800);
    wait_idle();
    rdc(4'h3, 16'h6206);
    pin(1'b0);
    rdc(4'hD, 16'h0101);
    rdc(4'hC, 16'h0102);
    // Thermal masked, flags cleared; extra and battery both included
    wr(4'h3, 16'hA00E);
    wr(4'h1, 16'h8800);
    wait_idle();
    rdc(4'h3, 16'hA80E);
    cmp(16'(extra_hits), 16'h0000);
    // Data-available, single Y channel, longer window
    wr(4'h3, 16'h0000);
    wr(4'h1, 16'hF500);
    wait_idle();
    pin(1'b0);
    rdc(4'h8, 16'h0107);
    cmp(16'(conv_count), 16'h0005);
    pin(1'b1);
    // Master, interval one, pin shows touch
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0002);
    wr(4'h1, 16'h0C01);
    repeat (100) @(negedge clk);
    cmp(16'(conv_count), 16'h0005);
    pin(1'b1);
    touch = 1'b1;
    pin(1'b0);
    repeat (1000) @(negedge clk);
    cmp(16'(conv_count), 16'h0006);
    repeat (2500) @(negedge clk);
    cmp(16'(conv_count), 16'h0007);
    touch = 1'b0;
    repeat (3000) @(negedge clk);
    cmp(16'(conv_count), 16'h0007);
    rdc(4'hD, 16'h0101);
    // GPIO on: extra channels skipped, then its alert path
    wr(4'h1, 16'h0000);
    gpio_en = 1'b1;
    wr(4'h3, 16'h200E);
    wr(4'h1, 16'h8800);
    wait_idle();
    rdc(4'h3, 16'h220E);
    cmp(16'(conv_count), 16'h0008);
    wr(4'h3, 16'h2000);
    pin(1'b1);
    gpio_al = 1'b1;
    pin(1'b0);
    wr(4'h3, 16'h3000);
    pin(1'b1);
    cmp(16'(act_cycles), 16'h0048);
    final_report();
  end
endmodule
